/* File: hdl/isp_status.sv */
/*
  Status, error detection, packet error check, DMA request and interrupt
  gating of an I2C/SMBus interface, with its APB register file.
  Assumes a bit/byte engine that reports bus events as one-cycle pulses
  in the pclk domain and asks for SDA drive through sda_drive_req.
*/
//
// Summary of operation
// - Unacknowledged byte or address at ninth clock sets no-acknowledge flag.
// - Start or stop not of our own making sets bus error flag.
// - Arbitration lost while master sets arbitration lost flag.
// - Slave receive of a new byte before old one read sets overrun.
// - Byte clock with no new byte written sets underrun.
// - Clock line low past fixed limit sets timeout flag.
// - Received check byte unequal to computed CRC sets mismatch flag.
// - CRC is 8 bits, polynomial x^8 + x^2 + x + 1.
// - With checking on, every bus byte including address feeds CRC.
// - DMA mode requests a write whenever transmit buffer is empty.
// - DMA mode requests a read whenever receive buffer is full.
// - Event flags interrupt only with event interrupt enable set.
// - Buffer flags interrupt only with event and buffer enables set.
// - Error flags and alert interrupt only with error enable set.
// - Registers at 0x00 to 0x20 in steps of four, switch at 0x100.
// - Comes up slave, becomes master after generating a start.
// - On arbitration loss stop driving the data line.
`timescale 1ns/1ps
`default_nettype none

module isp_status #(
  parameter int ADDR_W      = 12,
  parameter int TLOW_CYCLES = isp_pkg::TLOW_CYCLES
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire isp_pkg::isp_ev_t  ev,
  input  wire logic              scl_in,
  input  wire logic              alert_n_in,
  input  wire logic              sda_drive_req,
  output logic                   sda_oe,
  output logic                   alert_oe,
  output logic                   master_mode,
  output logic                   gen_start,
  output logic                   gen_stop,
  output logic                   ack_en,
  output logic [7:0]             tx_byte,
  output logic                   irq_event,
  output logic                   irq_error,
  output logic                   dma_tx_req,
  output logic                   dma_rx_req
);

  localparam int TW = $clog2(TLOW_CYCLES + 1);
  localparam logic [TW-1:0] TLOW_LIM = TW'(TLOW_CYCLES);

  logic [15:0]   ctrl1_q;
  logic [15:0]   ctrl2_q;
  logic [15:0]   oaddr1_q;
  logic [15:0]   oaddr2_q;
  logic [15:0]   clkc_q;
  logic [15:0]   rise_q;
  logic [15:0]   switch_q;
  logic [7:0]    rx_byte_q;
  logic [7:0]    crc_q;
  logic [7:0]    crc_d;
  logic [TW-1:0] low_cnt_q;
  logic          busy_q;
  logic          lost_q;
  logic [15:0]   flags;
  logic [15:0]   set_vec;
  logic [15:0]   clr_vec;
  logic [15:0]   rdata_d;
  logic          hit_d;

  // APB decode
  logic access;
  logic wr_en;
  logic rd_en;
  logic [11:0] addr12;

  assign access = psel && penable && !pready;
  assign wr_en  = access && pwrite && hit_d;
  assign rd_en  = access && !pwrite && hit_d;
  assign addr12 = 12'(paddr);

  wire enable    = ctrl1_q[isp_pkg::C1_ENABLE];
  wire crc_en    = ctrl1_q[isp_pkg::C1_CRCEN];
  wire smbus     = ctrl1_q[isp_pkg::C1_SMBUS];
  wire wr_ctrl1  = wr_en && (addr12 == isp_pkg::OFF_CTRL1);
  wire wr_buf    = wr_en && (addr12 == isp_pkg::OFF_BUF);
  wire rd_buf    = rd_en && (addr12 == isp_pkg::OFF_BUF);
  wire wr_sts1   = wr_en && (addr12 == isp_pkg::OFF_STS1);

  always_comb begin
    hit_d   = 1'b1;
    rdata_d = 16'h0000;
    case (addr12)
      isp_pkg::OFF_CTRL1:  rdata_d = ctrl1_q;
      isp_pkg::OFF_CTRL2:  rdata_d = ctrl2_q;
      isp_pkg::OFF_OADDR1: rdata_d = oaddr1_q;
      isp_pkg::OFF_OADDR2: rdata_d = oaddr2_q;
      isp_pkg::OFF_BUF:    rdata_d = {8'h00, rx_byte_q};
      isp_pkg::OFF_STS1:   rdata_d = flags;
      isp_pkg::OFF_STS2:   rdata_d = {crc_q, 6'h00, busy_q, master_mode};
      isp_pkg::OFF_CLKC:   rdata_d = clkc_q;
      isp_pkg::OFF_RISE:   rdata_d = rise_q;
      isp_pkg::OFF_SWITCH: rdata_d = switch_q;
      default:             hit_d   = 1'b0;
    endcase
  end

  // One wait state, then the answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access && !hit_d;
      if (access && !pwrite) begin
        prdata <= {16'h0000, rdata_d};
      end
    end
  end

  // control_one, with hardware-driven start, stop and acknowledge bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_q <= isp_pkg::RST_REG;
    end else begin
      if (wr_ctrl1) begin
        ctrl1_q <= pwdata[15:0];
      end
      if (ev.start_sent || !enable) begin
        ctrl1_q[isp_pkg::C1_START] <= 1'b0;
      end
      if (!enable) begin
        ctrl1_q[isp_pkg::C1_ACK] <= 1'b0;
      end
      if (ev.stop_seen && master_mode) begin
        ctrl1_q[isp_pkg::C1_STOP] <= 1'b0;
      end
      if (set_vec[isp_pkg::S_TLOW]) begin
        ctrl1_q[isp_pkg::C1_STOP] <= 1'b1;
      end
    end
  end

  // Plain storage registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl2_q  <= isp_pkg::RST_REG;
      oaddr1_q <= isp_pkg::RST_REG;
      oaddr2_q <= isp_pkg::RST_REG;
      clkc_q   <= isp_pkg::RST_REG;
      rise_q   <= isp_pkg::RST_REG;
      switch_q <= isp_pkg::RST_REG;
      tx_byte  <= 8'h00;
    end else if (wr_en) begin
      case (addr12)
        isp_pkg::OFF_CTRL2:  ctrl2_q  <= pwdata[15:0];
        isp_pkg::OFF_OADDR1: oaddr1_q <= pwdata[15:0];
        isp_pkg::OFF_OADDR2: oaddr2_q <= pwdata[15:0];
        isp_pkg::OFF_BUF:    tx_byte  <= pwdata[7:0];
        isp_pkg::OFF_CLKC:   clkc_q   <= pwdata[15:0];
        isp_pkg::OFF_RISE:   rise_q   <= pwdata[15:0];
        isp_pkg::OFF_SWITCH: switch_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Received byte holding register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_byte_q <= 8'h00;
    end else if (ev.rx_valid) begin
      rx_byte_q <= ev.rx_byte;
    end
  end

  // Master/slave mode and arbitration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_mode <= 1'b0;
      lost_q      <= 1'b0;
    end else begin
      if (!enable || set_vec[isp_pkg::S_ARB]) begin
        master_mode <= 1'b0;
      end else if (ev.start_sent) begin
        master_mode <= 1'b1;
      end else if (ev.stop_seen) begin
        master_mode <= 1'b0;
      end
      if (set_vec[isp_pkg::S_ARB]) begin
        lost_q <= 1'b1;
      end else if (ev.stop_det || !enable) begin
        lost_q <= 1'b0;
      end
    end
  end

  // Bus busy between start and stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else if (ev.stop_det || !enable) begin
      busy_q <= 1'b0;
    end else if (ev.start_det) begin
      busy_q <= 1'b1;
    end
  end

  // Data line drive, dropped once arbitration is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_oe <= 1'b0;
    end else begin
      sda_oe <= enable && sda_drive_req && !lost_q && !set_vec[isp_pkg::S_ARB];
    end
  end

  // Clock-low counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_q <= '0;
    end else if (!enable || scl_in) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q != TLOW_LIM) begin
      low_cnt_q <= low_cnt_q + TW'(1);
    end
  end

  wire tlow_hit = enable && !scl_in && (low_cnt_q == TLOW_LIM - TW'(1));

  // CRC accumulator
  isp_crc8 u_crc (
    .crc_in  (crc_q),
    .data    (ev.bus_byte),
    .crc_out (crc_d)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_q <= isp_pkg::CRC_INIT;
    end else if (!enable || !crc_en || ev.start_det || ev.stop_det) begin
      crc_q <= isp_pkg::CRC_INIT;
    end else if (ev.bus_valid) begin
      crc_q <= crc_d;
    end
  end

  // Flag set sources
  always_comb begin
    set_vec = 16'h0000;
    if (enable) begin
      set_vec[isp_pkg::S_START] = ev.start_sent;
      set_vec[isp_pkg::S_ADDR]  = ev.addr_done;
      set_vec[isp_pkg::S_BYTE]  = ev.byte_done;
      set_vec[isp_pkg::S_HDR10] = ev.hdr10_sent;
      set_vec[isp_pkg::S_STOP]  = ev.stop_seen && !master_mode;
      set_vec[isp_pkg::S_RXF]   = ev.rx_valid;
      set_vec[isp_pkg::S_TXE]   = ev.tx_clock;
      set_vec[isp_pkg::S_NACK]  = ev.nack;
      set_vec[isp_pkg::S_BERR]  = (ev.start_det || ev.stop_det) && !ev.own_cond;
      set_vec[isp_pkg::S_ARB]   = ev.arb_mismatch && master_mode;
      set_vec[isp_pkg::S_OVR]   = (ev.rx_valid && !master_mode && flags[isp_pkg::S_RXF])
                                || (ev.tx_clock && flags[isp_pkg::S_TXE]);
      set_vec[isp_pkg::S_CRC]   = crc_en && ev.pec_valid && (ev.rx_byte != crc_q);
      set_vec[isp_pkg::S_TLOW]  = tlow_hit;
      set_vec[isp_pkg::S_ALERT] = smbus && !alert_n_in;
    end
  end

  // Flag clear sources: write zero to clear, data access clears buffer flags
  always_comb begin
    clr_vec = 16'h0000;
    if (wr_sts1) begin
      clr_vec = ~pwdata[15:0] & isp_pkg::SW_CLR;
    end
    clr_vec[isp_pkg::S_RXF] = rd_buf;
    clr_vec[isp_pkg::S_TXE] = wr_buf;
    if (!enable) begin
      clr_vec = clr_vec | isp_pkg::EV_MASK | isp_pkg::BUF_MASK;
    end
  end

  for (genvar i = 0; i < 16; i++) begin : g_flag
    isp_flag #(
      .RESET_VAL (1'b0)
    ) u_flag (
      .pclk    (pclk),
      .presetn (presetn),
      .set     (set_vec[i]),
      .clr     (clr_vec[i]),
      .flag_q  (flags[i])
    );
  end

  // Interrupt and DMA requests
  wire ev_ien  = ctrl2_q[isp_pkg::C2_EVENT_IRQ_ENABLE];
  wire buf_ien = ctrl2_q[isp_pkg::C2_BUFFER_IRQ_ENABLE];
  wire err_ien = ctrl2_q[isp_pkg::C2_ERROR_IRQ_ENABLE];
  wire dma_en  = ctrl2_q[isp_pkg::C2_DMA_REQUEST_ENABLE];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_event <= 1'b0;
      irq_error <= 1'b0;
    end else begin
      irq_event <= (ev_ien && |(flags & isp_pkg::EV_MASK))
                || (ev_ien && buf_ien && |(flags & isp_pkg::BUF_MASK));
      irq_error <= err_ien && |(flags & isp_pkg::ERR_MASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_tx_req <= 1'b0;
      dma_rx_req <= 1'b0;
    end else begin
      dma_tx_req <= dma_en && flags[isp_pkg::S_TXE] && !wr_buf;
      dma_rx_req <= dma_en && flags[isp_pkg::S_RXF] && !rd_buf;
    end
  end

  // Control outputs to the engine and the alert pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_start <= 1'b0;
      gen_stop  <= 1'b0;
      ack_en    <= 1'b0;
      alert_oe  <= 1'b0;
    end else begin
      gen_start <= enable && ctrl1_q[isp_pkg::C1_START];
      gen_stop  <= enable && ctrl1_q[isp_pkg::C1_STOP];
      ack_en    <= enable && ctrl1_q[isp_pkg::C1_ACK];
      alert_oe  <= enable && smbus && ctrl1_q[isp_pkg::C1_ALERT];
    end
  end

endmodule // isp_status

`default_nettype wire

/* File: hdl/isp_pkg.sv */
/*
  Package of the I2C status, error, packet check and DMA request block:
  register offsets, field positions, reset values, timing counts, event carrier.
  Assumes a 40 MHz APB clock.
*/
package isp_pkg;

  // Register byte offsets
  localparam logic [11:0] OFF_CTRL1  = 12'h000;
  localparam logic [11:0] OFF_CTRL2  = 12'h004;
  localparam logic [11:0] OFF_OADDR1 = 12'h008;
  localparam logic [11:0] OFF_OADDR2 = 12'h00C;
  localparam logic [11:0] OFF_BUF    = 12'h010;
  localparam logic [11:0] OFF_STS1   = 12'h014;
  localparam logic [11:0] OFF_STS2   = 12'h018;
  localparam logic [11:0] OFF_CLKC   = 12'h01C;
  localparam logic [11:0] OFF_RISE   = 12'h020;
  localparam logic [11:0] OFF_SWITCH = 12'h100;

  localparam logic [15:0] RST_REG = 16'h0000;

  // control_one fields
  localparam int C1_ENABLE = 0;
  localparam int C1_SMBUS  = 1;
  localparam int C1_CRCEN  = 5;
  localparam int C1_START  = 8;
  localparam int C1_STOP   = 9;
  localparam int C1_ACK    = 10;
  localparam int C1_ALERT  = 13;

  // control_two fields
  localparam int C2_EVENT_IRQ_ENABLE  = 8;
  localparam int C2_BUFFER_IRQ_ENABLE = 9;
  localparam int C2_ERROR_IRQ_ENABLE = 10;
  localparam int C2_DMA_REQUEST_ENABLE  = 11;

  // status_one fields
  localparam int S_START = 0;
  localparam int S_ADDR  = 1;
  localparam int S_BYTE  = 2;
  localparam int S_HDR10 = 3;
  localparam int S_STOP  = 4;
  localparam int S_RXF   = 6;
  localparam int S_TXE   = 7;
  localparam int S_BERR  = 8;
  localparam int S_ARB   = 9;
  localparam int S_NACK  = 10;
  localparam int S_OVR   = 11;
  localparam int S_CRC   = 12;
  localparam int S_TLOW  = 14;
  localparam int S_ALERT = 15;

  // Groups of status_one bits
  localparam logic [15:0] EV_MASK  = 16'h001F;
  localparam logic [15:0] BUF_MASK = 16'h00C0;
  localparam logic [15:0] ERR_MASK = 16'hDF00;
  localparam logic [15:0] SW_CLR   = 16'hDF1F;

  // status_two fields
  localparam int S2_MASTER = 0;
  localparam int S2_BUSY   = 1;
  localparam int S2_CRC_LO = 8;

  // CRC-8, x^8 + x^2 + x + 1
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // Clock-low limit
  localparam int CLK_HZ      = 40_000_000;
  localparam int TLOW_US     = 25_000;
  localparam int TLOW_CYCLES = TLOW_US * (CLK_HZ / 1_000_000);

  // Events from the bit/byte engine, one-cycle pulses
  typedef struct packed {
    logic       start_sent;
    logic       addr_done;
    logic       hdr10_sent;
    logic       stop_seen;
    logic       byte_done;
    logic       start_det;
    logic       stop_det;
    logic       own_cond;
    logic       nack;
    logic       arb_mismatch;
    logic       rx_valid;
    logic       tx_clock;
    logic       bus_valid;
    logic       pec_valid;
    logic [7:0] rx_byte;
    logic [7:0] bus_byte;
  } isp_ev_t;

endpackage

/* File: hdl/isp_flag.sv */
/*
  One sticky status flag: hardware set, clear from software or hardware.
  Assumes set and clear are single-cycle pulses in the pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none

module isp_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set,
  input  wire logic clr,
  output var  logic flag_q
);

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= RESET_VAL;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end

endmodule // isp_flag

`default_nettype wire

/* File: hdl/isp_crc8.sv */
/*
  Combinational CRC-8 step over one byte, most significant bit first.
  Assumes the caller holds the running value in its own register.
*/
`timescale 1ns/1ps
`default_nettype none

module isp_crc8 (
  input  wire logic [7:0] crc_in,
  input  wire logic [7:0] data,
  output logic      [7:0] crc_out
);

  always_comb begin
    logic [7:0] c;
    c = crc_in ^ data;
    for (int i = 0; i < 8; i++) begin
      if (c[7]) begin
        c = {c[6:0], 1'b0} ^ isp_pkg::CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc_out = c;
  end

endmodule // isp_crc8

`default_nettype wire

/* File: tb/isp_status_properties.sv */
/*
  Checker of isp_status ports: APB answer, interrupt and DMA gating,
  SDA release, master entry and clock-low timeout.
  Assumes enables are mirrored from completed APB writes.
*/
`timescale 1ns/1ps
`default_nettype none

module isp_status_properties #(
  parameter int ADDR_W      = 12,
  parameter int TLOW_CYCLES = 20
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire isp_pkg::isp_ev_t  ev,
  input wire logic              scl_in,
  input wire logic              sda_oe,
  input wire logic              master_mode,
  input wire logic              gen_stop,
  input wire logic              irq_event,
  input wire logic              irq_error,
  input wire logic              dma_tx_req,
  input wire logic              dma_rx_req
);
  logic en_q, evie_q, erri_q, dma_q, hit, mapped;
  int   low_q;

  assign hit    = psel && penable && !pready;
  assign mapped = (paddr[1:0] == 2'b00 && paddr <= ADDR_W'(12'h020)) || paddr == ADDR_W'(12'h100);

  // Software enables as last written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q   <= 1'b0;
      evie_q <= 1'b0;
      erri_q <= 1'b0;
      dma_q  <= 1'b0;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == ADDR_W'(isp_pkg::OFF_CTRL1)) en_q <= pwdata[isp_pkg::C1_ENABLE];
      if (paddr == ADDR_W'(isp_pkg::OFF_CTRL2)) begin
        evie_q <= pwdata[isp_pkg::C2_EVENT_IRQ_ENABLE];
        erri_q <= pwdata[isp_pkg::C2_ERROR_IRQ_ENABLE];
        dma_q  <= pwdata[isp_pkg::C2_DMA_REQUEST_ENABLE];
      end
    end
  end

  // Consecutive clock-low cycles while enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_q <= 0;
    else if (scl_in || !en_q) low_q <= 0;
    else if (low_q <= TLOW_CYCLES) low_q <= low_q + 1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_pulse: assert property (hit |=> pready)
    else $error("no ready one cycle after access");
  a_unmapped_err: assert property (hit && !mapped |=> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (hit && mapped |=> !pslverr)
    else $error("mapped access flagged as error");
  a_err_gate: assert property (!erri_q |-> !irq_error)
    else $error("error interrupt while disabled");
  a_evt_gate: assert property (!evie_q |-> !irq_event)
    else $error("event interrupt while disabled");
  a_dma_gate: assert property (!dma_q |-> !dma_tx_req && !dma_rx_req)
    else $error("dma request while disabled");
  a_nack_irq: assert property (en_q && erri_q && ev.nack |=> ##1 irq_error)
    else $error("nack did not raise error interrupt");
  a_sda_release: assert property (ev.arb_mismatch |=> !sda_oe)
    else $error("data line still driven after lost arbitration");
  a_master_start: assert property (en_q && ev.start_sent |=> master_mode)
    else $error("no master mode after start");
  a_tlow_stop: assert property (low_q == TLOW_CYCLES |-> ##[0:4] gen_stop)
    else $error("clock low timeout without stop");
endmodule // isp_status_properties

bind isp_status isp_status_properties #(.ADDR_W(ADDR_W), .TLOW_CYCLES(TLOW_CYCLES)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .ev(ev),
  .scl_in(scl_in), .sda_oe(sda_oe), .master_mode(master_mode), .gen_stop(gen_stop),
  .irq_event(irq_event), .irq_error(irq_error), .dma_tx_req(dma_tx_req),
  .dma_rx_req(dma_rx_req));

`default_nettype wire

/* File: tb/isp_bus_peer.sv */
/*
  Far-side device on the two-wire bus: stretches the clock line low for a
  given count and pulls the alert line. Assumes pull-ups, released is high.
*/
`timescale 1ns/1ps
`default_nettype none

module isp_bus_peer (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       stretch_go,
  input  wire logic [7:0] stretch_len,
  input  wire logic       alert_req,
  output logic            scl_line,
  output logic            alert_n_line
);
  logic [7:0] hold_q;
  logic       alert_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hold_q <= 8'h00;
    else if (stretch_go) hold_q <= stretch_len;
    else if (hold_q != 8'h00) hold_q <= hold_q - 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) alert_q <= 1'b0;
    else alert_q <= alert_req;
  end

  // Clock stands high between stretches
  assign scl_line     = (hold_q == 8'h00);
  assign alert_n_line = !alert_q;
endmodule // isp_bus_peer

`default_nettype wire

/* File: tb/isp_status_bench.sv */
/*
  Self-checking bench of isp_status: registers over APB, event and error
  flags, interrupt and DMA gating, CRC, timeout and alert.
  Assumes the bit engine's events are driven here as one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none

module isp_status_bench;
  localparam int          TLOW = 20;
  localparam logic [31:0] EN   = 32'h0000_0001;
  localparam logic [31:0] SMB  = 32'h0000_0002;
  localparam logic [31:0] CRCE = 32'h0000_0020;
  localparam logic [31:0] EVI  = 32'h0000_0100;
  localparam logic [31:0] BUFI = 32'h0000_0200;
  localparam logic [31:0] ERRI = 32'h0000_0400;
  localparam logic [31:0] DMAE = 32'h0000_0800;
  logic              pclk = 1'b0;
  logic              presetn, psel, penable, pwrite, sda_drive_req, stretch_go, alert_req;
  logic              scl_in, alert_n_in, pready, pslverr, sda_oe, alert_oe, master_mode;
  logic              gen_start, gen_stop, ack_en, irq_event, irq_error, dma_tx_req, dma_rx_req;
  logic              se;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, r, d;
  logic [7:0]        tx_byte, b, c;
  isp_pkg::isp_ev_t  ev, e;
  int                num_errors = 0;
  int                checked = 0;
  integer            seed = 99993;
  int                errs [3] = '{10, 8, 9};
  logic [11:0]       map_a [10] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010,
                                    12'h014, 12'h018, 12'h01C, 12'h020, 12'h100};

  always #12.5 pclk = ~pclk;

  isp_status #(.TLOW_CYCLES(TLOW)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ev(ev), .scl_in(scl_in), .alert_n_in(alert_n_in), .sda_drive_req(sda_drive_req),
    .sda_oe(sda_oe), .alert_oe(alert_oe), .master_mode(master_mode), .gen_start(gen_start),
    .gen_stop(gen_stop), .ack_en(ack_en), .tx_byte(tx_byte), .irq_event(irq_event),
    .irq_error(irq_error), .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req));

  isp_bus_peer peer (
    .pclk(pclk), .presetn(presetn), .stretch_go(stretch_go), .stretch_len(8'(TLOW + 4)),
    .alert_req(alert_req), .scl_line(scl_in), .alert_n_line(alert_n_in));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    se = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic pulse(input isp_pkg::isp_ev_t p);
    @(posedge pclk);
    ev <= p;
    @(posedge pclk);
    ev <= '0;
  endtask

  task automatic flag(input int k, input logic v);
    rd(isp_pkg::OFF_STS1);
    chk(32'(r[k]), 32'(v));
  endtask

  task automatic clr(input int k);
    wr(isp_pkg::OFF_STS1, 32'(~(16'h0001 << k)));
    idle(2);
  endtask

  function automatic isp_pkg::isp_ev_t ev_of(input int k);
    isp_pkg::isp_ev_t p;
    p = '0;
    case (k)
      0: p.start_sent = 1'b1;
      1: p.addr_done = 1'b1;
      2: p.byte_done = 1'b1;
      3: p.hdr10_sent = 1'b1;
      4: p.stop_seen = 1'b1;
      8: p.start_det = 1'b1;
      9: p.arb_mismatch = 1'b1;
      default: p.nack = 1'b1;
    endcase
    return p;
  endfunction

  // Serial CRC-8, most significant bit first
  function automatic logic [7:0] crc8(input logic [7:0] cv, input logic [7:0] bv);
    for (int i = 7; i >= 0; i--) cv = {cv[6:0], 1'b0} ^ ((cv[7] ^ bv[i]) ? 8'h07 : 8'h00);
    return cv;
  endfunction

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    print_verdict;
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, sda_drive_req, stretch_go, alert_req} = '0;
    paddr = '0;
    pwdata = '0;
    ev = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rd(map_a[i]);
      chk(r, 32'h0000_0000);
      chk(32'(se), 32'h0000_0000);
      if (i inside {2, 3, 7, 8, 9}) begin
        d = $random(seed);
        wr(map_a[i], d);
        rd(map_a[i]);
        chk(r, {16'h0000, d[15:0]});
      end
    end
    apb(1'b0, 12'h024, 32'h0000_0000);
    chk(32'(se), 32'h0000_0001);
    chk(r, 32'h0000_0000);
    chk(32'(master_mode), 32'h0000_0000);
    $display("test registers done");
    wr(isp_pkg::OFF_CTRL1, EN);
    pulse(ev_of(10));
    flag(10, 1'b1);
    chk(32'(irq_error), 32'h0000_0000);
    wr(isp_pkg::OFF_CTRL2, ERRI);
    idle(2);
    chk(32'(irq_error), 32'h0000_0001);
    clr(10);
    pulse(ev_of(2));
    idle(2);
    chk(32'(irq_event), 32'h0000_0000);
    wr(isp_pkg::OFF_CTRL2, EVI | ERRI);
    idle(2);
    chk(32'(irq_event), 32'h0000_0001);
    clr(2);
    for (int k = 4; k >= 0; k--) begin
      pulse(ev_of(k));
      flag(k, 1'b1);
      chk(32'(irq_event), 32'h0000_0001);
      clr(k);
      chk(32'(irq_event), 32'h0000_0000);
    end
    chk(32'(master_mode), 32'h0000_0001);
    sda_drive_req <= 1'b1;
    idle(3);
    chk(32'(sda_oe), 32'h0000_0001);
    foreach (errs[i]) begin
      pulse(ev_of(errs[i]));
      idle(6);
      flag(errs[i], 1'b1);
      chk(32'(irq_error), 32'h0000_0001);
      clr(errs[i]);
      chk(32'(irq_error), 32'h0000_0000);
    end
    chk(32'(sda_oe), 32'h0000_0000);
    sda_drive_req <= 1'b0;
    $display("test events done");
    wr(isp_pkg::OFF_CTRL1, EN | CRCE);
    e = ev_of(8);
    e.own_cond = 1'b1;
    pulse(e);
    flag(8, 1'b0);
    c = 8'h00;
    for (int i = 0; i < 3; i++) begin
      b = 8'($random(seed));
      e = '0;
      e.bus_valid = 1'b1;
      e.bus_byte = b;
      pulse(e);
      c = crc8(c, b);
    end
    rd(isp_pkg::OFF_STS2);
    chk(32'(r[15:8]), 32'(c));
    e = '0;
    e.pec_valid = 1'b1;
    e.rx_byte = c;
    pulse(e);
    flag(12, 1'b0);
    e.rx_byte = c ^ 8'h01;
    pulse(e);
    flag(12, 1'b1);
    clr(12);
    e = '0;
    e.stop_det = 1'b1;
    e.own_cond = 1'b1;
    pulse(e);
    rd(isp_pkg::OFF_STS2);
    chk(32'(r[15:8]), 32'h0000_0000);
    $display("test crc done");
    wr(isp_pkg::OFF_CTRL2, EVI | ERRI);
    b = 8'($random(seed));
    e = '0;
    e.rx_valid = 1'b1;
    e.rx_byte = b;
    pulse(e);
    flag(6, 1'b1);
    chk(32'(irq_event), 32'h0000_0000);
    wr(isp_pkg::OFF_CTRL2, EVI | BUFI | ERRI | DMAE);
    idle(2);
    chk(32'(irq_event), 32'h0000_0001);
    chk(32'(dma_rx_req), 32'h0000_0001);
    e.rx_byte = ~b;
    pulse(e);
    flag(11, 1'b1);
    rd(isp_pkg::OFF_BUF);
    chk(r, {24'h00_0000, ~b});
    idle(2);
    chk(32'(dma_rx_req), 32'h0000_0000);
    clr(11);
    e = '0;
    e.tx_clock = 1'b1;
    pulse(e);
    idle(2);
    chk(32'(dma_tx_req), 32'h0000_0001);
    pulse(e);
    flag(11, 1'b1);
    b = 8'($random(seed));
    wr(isp_pkg::OFF_BUF, {24'h00_0000, b});
    idle(2);
    chk(32'(dma_tx_req), 32'h0000_0000);
    chk(32'(tx_byte), 32'(b));
    $display("test buffers done");
    stretch_go <= 1'b1;
    @(posedge pclk);
    stretch_go <= 1'b0;
    idle(TLOW + 8);
    flag(14, 1'b1);
    chk(32'(gen_stop), 32'h0000_0001);
    wr(isp_pkg::OFF_CTRL1, EN | SMB | 32'h0000_2500);
    alert_req <= 1'b1;
    idle(4);
    flag(15, 1'b1);
    chk(32'({gen_start, ack_en, alert_oe}), 32'h0000_0007);
    alert_req <= 1'b0;
    $display("test timeout and alert done");
    print_verdict;
  end
endmodule // isp_status_bench

`default_nettype wire
